// ### design/bci_pkg.sv
// shared types and constants for the instruction-subset core and its file bank
// assumes one 10 MHz clock, synchronous active-high reset, classic wishbone master
package bci_pkg;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [7:0] adr;
    logic [31:0] dat;
  } bci_wb_req_t;

  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } bci_wb_rsp_t;

  typedef enum logic [1:0] {
    BCI_IDLE = 2'b00,
    BCI_EXEC = 2'b01,
    BCI_RET2 = 2'b10,
    BCI_SLEEP = 2'b11
  } bci_fsm_t;

  typedef struct packed {
    bci_fsm_t st;
    logic [11:0] ir;
    logic [7:0] w;
    logic [7:0] opt;
    logic [8:0] pc;
    logic [8:0] stack_top_entry;
    logic c;
    logic z;
    logic pd;
    logic to;
    logic wkf;
    logic [7:0] wdt;
    logic [7:0] pre;
    logic ack;
    logic [31:0] dat;
  } bci_state_t;

  typedef struct packed {
    logic [31:0][7:0] mem;
  } bci_bank_t;

  // register byte offsets
  localparam logic [7:0] BCI_OFS_INSTR = 8'h00;
  localparam logic [7:0] BCI_OFS_STATUS = 8'h04;
  localparam logic [7:0] BCI_OFS_WREG = 8'h08;
  localparam logic [7:0] BCI_OFS_OPTION = 8'h0C;
  localparam logic [7:0] BCI_OFS_PC = 8'h10;
  localparam logic [7:0] BCI_OFS_STACK = 8'h14;
  localparam logic [7:0] BCI_OFS_CORE = 8'h18;
  localparam logic [7:0] BCI_OFS_WDT = 8'h1C;
  localparam logic [7:0] BCI_OFS_FILE = 8'h80;

  // status register bit positions
  localparam int BCI_ST_C = 0;
  localparam int BCI_ST_Z = 2;
  localparam int BCI_ST_PD = 3;
  localparam int BCI_ST_TO = 4;
  localparam int BCI_ST_WKF = 7;

  // core register bit positions
  localparam int BCI_CORE_BUSY = 0;
  localparam int BCI_CORE_ASLEEP = 1;
  localparam int BCI_CORE_WAKE = 0;

  // instruction fields and encodings
  localparam int BCI_D_BIT = 5;
  localparam logic [11:0] BCI_MSK_FD = 12'hFC0;
  localparam logic [11:0] BCI_MSK_LIT = 12'hF00;
  localparam logic [11:0] BCI_MSK_ALL = 12'hFFF;
  localparam logic [11:0] BCI_OP_MOVE_FILE = 12'h200;
  localparam logic [11:0] BCI_OP_ROTATE_LEFT = 12'h340;
  localparam logic [11:0] BCI_OP_LOAD_LITERAL = 12'hC00;
  localparam logic [11:0] BCI_OP_RETURN_LITERAL = 12'h800;
  localparam logic [11:0] BCI_OP_IDLE = 12'h000;
  localparam logic [11:0] BCI_OP_LOAD_OPTION = 12'h002;
  localparam logic [11:0] BCI_OP_SLEEP = 12'h003;

  localparam logic [7:0] BCI_WDT_LAST = 8'hFF;
  localparam logic [7:0] BCI_RST_OPT = 8'hFF;
  localparam logic BCI_RST_TO = 1'b1;
  localparam logic BCI_RST_PD = 1'b1;

  localparam bci_state_t BCI_STATE_RST = '{
    st: BCI_IDLE, ir: 12'h000, w: 8'h00, opt: BCI_RST_OPT, pc: 9'h000, stack_top_entry: 9'h000,
    c: 1'b0, z: 1'b0, pd: BCI_RST_PD, to: BCI_RST_TO, wkf: 1'b0,
    wdt: 8'h00, pre: 8'h00, ack: 1'b0, dat: 32'h0000_0000};

endpackage

// ### design/bci_file_bank.sv
// 32 x 8 file register bank with one write port and two read ports
// assumes the writer never drives two sources at once; reads are combinational
module bci_file_bank (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic we_i,
  input wire logic [4:0] waddr_i,
  input wire logic [7:0] wdata_i,
  input wire logic [4:0] raddr_a_i,
  input wire logic [4:0] raddr_b_i,
  output logic [7:0] rdata_a_o,
  output logic [7:0] rdata_b_o
);
  import bci_pkg::*;

  bci_bank_t s_r;
  bci_bank_t s_nxt;

  always_comb
  begin
    s_nxt = s_r;
    if (we_i)
    begin
      s_nxt.mem[waddr_i] = wdata_i;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s_r <= '0;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  assign rdata_a_o = s_r.mem[raddr_a_i];
  assign rdata_b_o = s_r.mem[raddr_b_i];

endmodule

// ### design/bci_core.sv
// execution core for a small instruction subset, driven over a wishbone slave
// assumes a classic single-cycle wishbone master and one 10 MHz clock
//
// Decided for this implementation: the Wishbone register port and the register offsets.
module bci_core #(
  parameter int unsigned WDT_PRESCALE = 256
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input bci_pkg::bci_wb_req_t wb_req_i,
  output bci_pkg::bci_wb_rsp_t wb_rsp_o,
  output logic sleeping_o,
  output logic [7:0] option_o
);
  import bci_pkg::*;

  bci_state_t s_r;
  bci_state_t s_nxt;

  logic fb_we;
  logic [4:0] fb_waddr;
  logic [7:0] fb_wdata;
  logic [7:0] fval;
  logic [7:0] bval;
  logic [31:0] rd_data;
  logic req_hit;
  logic bus_wr;
  logic bus_quiet;
  logic [8:0] rot;

  function automatic logic op_is(input logic [11:0] ir, input logic [11:0] msk,
                                 input logic [11:0] op);
    op_is = (ir & msk) == op;
  endfunction

  function automatic logic [31:0] sel_merge(input logic [31:0] old, input logic [31:0] nw,
                                            input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
    begin
      if (sel[i])
      begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    sel_merge = r;
  endfunction

  function automatic logic [7:0] pack_status(input bci_state_t s);
    logic [7:0] r;
    r = 8'h00;
    r[BCI_ST_C] = s.c;
    r[BCI_ST_Z] = s.z;
    r[BCI_ST_PD] = s.pd;
    r[BCI_ST_TO] = s.to;
    r[BCI_ST_WKF] = s.wkf;
    pack_status = r;
  endfunction

  logic ex;
  logic is_move;
  logic is_rot;
  logic is_lit;
  logic is_ret;
  logic is_idle;
  logic is_opt;
  logic is_sleep;
  logic dbit;

  assign ex = s_r.st == BCI_EXEC;
  assign is_move = op_is(s_r.ir, BCI_MSK_FD, BCI_OP_MOVE_FILE);
  assign is_rot = op_is(s_r.ir, BCI_MSK_FD, BCI_OP_ROTATE_LEFT);
  assign is_lit = op_is(s_r.ir, BCI_MSK_LIT, BCI_OP_LOAD_LITERAL);
  assign is_ret = op_is(s_r.ir, BCI_MSK_LIT, BCI_OP_RETURN_LITERAL);
  assign is_idle = op_is(s_r.ir, BCI_MSK_ALL, BCI_OP_IDLE);
  assign is_opt = op_is(s_r.ir, BCI_MSK_ALL, BCI_OP_LOAD_OPTION);
  assign is_sleep = op_is(s_r.ir, BCI_MSK_ALL, BCI_OP_SLEEP);
  assign dbit = s_r.ir[BCI_D_BIT];
  assign rot = {fval, s_r.c};

  assign req_hit = wb_req_i.cyc & wb_req_i.stb;
  assign bus_wr = req_hit & wb_req_i.we & s_r.ack;
  assign bus_quiet = (s_r.st == BCI_IDLE) || (s_r.st == BCI_SLEEP);

  bci_file_bank u_bank (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .we_i(fb_we),
    .waddr_i(fb_waddr),
    .wdata_i(fb_wdata),
    .raddr_a_i(s_r.ir[4:0]),
    .raddr_b_i(wb_req_i.adr[6:2]),
    .rdata_a_o(fval),
    .rdata_b_o(bval)
  );

  // read data mux, sampled into the answer register when ack is issued
  always_comb
  begin
    rd_data = 32'h0000_0000;
    if (wb_req_i.adr[7])
    begin
      rd_data = {24'h00_0000, bval};
    end
    else if (wb_req_i.adr == BCI_OFS_INSTR)
    begin
      rd_data = {20'h0_0000, s_r.ir};
    end
    else if (wb_req_i.adr == BCI_OFS_STATUS)
    begin
      rd_data = {24'h00_0000, pack_status(s_r)};
    end
    else if (wb_req_i.adr == BCI_OFS_WREG)
    begin
      rd_data = {24'h00_0000, s_r.w};
    end
    else if (wb_req_i.adr == BCI_OFS_OPTION)
    begin
      rd_data = {24'h00_0000, s_r.opt};
    end
    else if (wb_req_i.adr == BCI_OFS_PC)
    begin
      rd_data = {23'h00_0000, s_r.pc};
    end
    else if (wb_req_i.adr == BCI_OFS_STACK)
    begin
      rd_data = {23'h00_0000, s_r.stack_top_entry};
    end
    else if (wb_req_i.adr == BCI_OFS_CORE)
    begin
      rd_data[BCI_CORE_BUSY] = (s_r.st == BCI_EXEC) || (s_r.st == BCI_RET2);
      rd_data[BCI_CORE_ASLEEP] = s_r.st == BCI_SLEEP;
    end
    else if (wb_req_i.adr == BCI_OFS_WDT)
    begin
      rd_data = {24'h00_0000, s_r.wdt};
    end
  end

  always_comb
  begin
    logic [31:0] wv;
    logic wake;
    wv = 32'h0000_0000;
    wake = 1'b0;
    s_nxt = s_r;
    fb_we = 1'b0;
    fb_waddr = s_r.ir[4:0];
    fb_wdata = 8'h00;

    // bus slave: ack one cycle after the request, dropped the cycle after
    s_nxt.ack = req_hit & ~s_r.ack;
    if (req_hit & ~s_r.ack)
    begin
      s_nxt.dat = rd_data;
    end

    // watchdog: prescaler then counter; overflow clears time-out and wakes
    if (s_r.pre == 8'(WDT_PRESCALE - 1))
    begin
      s_nxt.pre = 8'h00;
      if (s_r.wdt == BCI_WDT_LAST)
      begin
        s_nxt.wdt = 8'h00;
        s_nxt.to = 1'b0;
        wake = 1'b1;
      end
      else
      begin
        s_nxt.wdt = s_r.wdt + 8'h01;
      end
    end
    else
    begin
      s_nxt.pre = s_r.pre + 8'h01;
    end

    // register writes take effect at the edge where ack is sampled
    if (bus_wr)
    begin
      if (wb_req_i.adr[7])
      begin
        if (bus_quiet && wb_req_i.sel[0])
        begin
          fb_we = 1'b1;
          fb_waddr = wb_req_i.adr[6:2];
          fb_wdata = wb_req_i.dat[7:0];
        end
      end
      else if (wb_req_i.adr == BCI_OFS_INSTR)
      begin
        if (s_r.st == BCI_IDLE)
        begin
          wv = sel_merge({20'h0_0000, s_r.ir}, wb_req_i.dat, wb_req_i.sel);
          s_nxt.ir = wv[11:0];
          s_nxt.st = BCI_EXEC;
        end
      end
      else if (wb_req_i.adr == BCI_OFS_STATUS)
      begin
        if (bus_quiet && wb_req_i.sel[0])
        begin
          s_nxt.c = wb_req_i.dat[BCI_ST_C];
          s_nxt.z = wb_req_i.dat[BCI_ST_Z];
          s_nxt.wkf = wb_req_i.dat[BCI_ST_WKF];
        end
      end
      else if (wb_req_i.adr == BCI_OFS_WREG)
      begin
        if (bus_quiet && wb_req_i.sel[0])
        begin
          s_nxt.w = wb_req_i.dat[7:0];
        end
      end
      else if (wb_req_i.adr == BCI_OFS_PC)
      begin
        if (bus_quiet)
        begin
          wv = sel_merge({23'h00_0000, s_r.pc}, wb_req_i.dat, wb_req_i.sel);
          s_nxt.pc = wv[8:0];
        end
      end
      else if (wb_req_i.adr == BCI_OFS_STACK)
      begin
        if (bus_quiet)
        begin
          wv = sel_merge({23'h00_0000, s_r.stack_top_entry}, wb_req_i.dat, wb_req_i.sel);
          s_nxt.stack_top_entry = wv[8:0];
        end
      end
      else if (wb_req_i.adr == BCI_OFS_CORE)
      begin
        if (wb_req_i.sel[0] && wb_req_i.dat[BCI_CORE_WAKE])
        begin
          wake = 1'b1;
        end
      end
    end

    case (s_r.st)
      BCI_IDLE:
      begin
      end
      BCI_EXEC:
      begin
        s_nxt.st = BCI_IDLE;
        s_nxt.pc = s_r.pc + 9'h001;
        if (is_move)
        begin
          s_nxt.z = fval == 8'h00;
          if (dbit)
          begin
            fb_we = 1'b1;
            fb_wdata = fval;
          end
          else
          begin
            s_nxt.w = fval;
          end
        end
        else if (is_rot)
        begin
          s_nxt.c = rot[8];
          if (dbit)
          begin
            fb_we = 1'b1;
            fb_wdata = rot[7:0];
          end
          else
          begin
            s_nxt.w = rot[7:0];
          end
        end
        else if (is_lit)
        begin
          s_nxt.w = s_r.ir[7:0];
        end
        else if (is_ret)
        begin
          s_nxt.w = s_r.ir[7:0];
          s_nxt.st = BCI_RET2;
          s_nxt.pc = s_r.pc;
        end
        else if (is_opt)
        begin
          s_nxt.opt = s_r.w;
        end
        else if (is_sleep)
        begin
          s_nxt.wdt = 8'h00;
          s_nxt.pre = 8'h00;
          s_nxt.to = 1'b1;
          s_nxt.pd = 1'b0;
          s_nxt.st = BCI_SLEEP;
        end
      end
      BCI_RET2:
      begin
        s_nxt.pc = s_r.stack_top_entry;
        s_nxt.st = BCI_IDLE;
      end
      BCI_SLEEP:
      begin
        if (wake)
        begin
          s_nxt.st = BCI_IDLE;
        end
      end
      default:
      begin
        s_nxt.st = BCI_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s_r <= BCI_STATE_RST;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  assign wb_rsp_o = '{ack: s_r.ack, dat: s_r.dat};
  assign sleeping_o = s_r.st == BCI_SLEEP;
  assign option_o = s_r.opt;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  property p_move_dest;
    ex && is_move |=> $past(dbit) ? (fval == $past(fval) && s_r.w == $past(s_r.w))
      : (s_r.w == $past(fval));
  endproperty
  a_move_dest: assert property (p_move_dest) else $error("move-file result misplaced");

  property p_move_flags;
    ex && is_move |=> s_r.z == ($past(fval) == 8'h00) && s_r.c == $past(s_r.c)
      && (s_r.to == $past(s_r.to) || !s_r.to) && s_r.pd == $past(s_r.pd)
      && s_r.wkf == $past(s_r.wkf);
  endproperty
  a_move_flags: assert property (p_move_flags) else $error("move-file flags wrong");

  property p_literal;
    ex && is_lit |=> s_r.w == $past(s_r.ir[7:0]) && s_r.c == $past(s_r.c)
      && s_r.z == $past(s_r.z) && s_r.pd == $past(s_r.pd) && s_r.wkf == $past(s_r.wkf);
  endproperty
  a_literal: assert property (p_literal) else $error("load-literal wrong");

  property p_option;
    ex && is_opt |=> option_o == $past(s_r.w) && s_r.z == $past(s_r.z);
  endproperty
  a_option: assert property (p_option) else $error("load-option wrong");

  sequence s_ret_start;
    ex && is_ret;
  endsequence
  sequence s_ret_end;
    s_r.st == BCI_RET2 ##1 s_r.st == BCI_IDLE && s_r.pc == $past(s_r.stack_top_entry, 2);
  endsequence
  property p_return;
    s_ret_start |=> s_r.w == $past(s_r.ir[7:0]) ##0 s_ret_end;
  endproperty
  a_return: assert property (p_return) else $error("return-literal wrong");

  property p_sleep_wdt;
    ex && is_sleep |=> s_r.wdt == 8'h00 && s_r.pre == 8'h00;
  endproperty
  a_sleep_wdt: assert property (p_sleep_wdt) else $error("sleep left watchdog running");

  property p_sleep_flags;
    ex && is_sleep |=> s_r.to && !s_r.pd && s_r.wkf == $past(s_r.wkf);
  endproperty
  a_sleep_flags: assert property (p_sleep_flags) else $error("sleep status bits wrong");

  property p_sleep_halt;
    sleeping_o && !$past(sleeping_o) |-> s_r.pc == $past(s_r.pc) + 9'h001 ##1
      (sleeping_o || s_r.st == BCI_IDLE);
  endproperty
  a_sleep_halt: assert property (p_sleep_halt) else $error("core ran while asleep");

  // only a bus write may move the program counter while asleep
  property p_sleep_hold;
    sleeping_o |=> s_r.st != BCI_EXEC && (s_r.pc == $past(s_r.pc) || $past(bus_wr));
  endproperty
  a_sleep_hold: assert property (p_sleep_hold) else $error("instruction ran asleep");

  property p_rotate;
    ex && is_rot |=> s_r.c == $past(fval[7]) && s_r.z == $past(s_r.z);
  endproperty
  a_rotate: assert property (p_rotate) else $error("rotate carry wrong");

  property p_rotate_dest;
    ex && is_rot |=> ($past(dbit) ? fval : s_r.w) == {$past(fval[6:0]), $past(s_r.c)};
  endproperty
  a_rotate_dest: assert property (p_rotate_dest) else $error("rotate result wrong");

  property p_idle;
    ex && is_idle |=> s_r.pc == $past(s_r.pc) + 9'h001 && s_r.w == $past(s_r.w)
      && s_r.opt == $past(s_r.opt) && s_r.c == $past(s_r.c) && s_r.z == $past(s_r.z);
  endproperty
  a_idle: assert property (p_idle) else $error("idle op changed state");

  property p_single;
    ex && !is_ret && !is_sleep |=> s_r.st == BCI_IDLE;
  endproperty
  a_single: assert property (p_single) else $error("op took more than one cycle");

endmodule

// ### testbench/testbench.sv
// self-checking bench for the instruction-subset core, driven over its wishbone slave port
// assumes the core answers each request with a one-cycle ack and runs on one 100 ns clock
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import bci_pkg::*;

  typedef struct packed {
    logic [11:0] ins;
    logic [7:0] fv;
    logic c_in;
    logic z_in;
    logic [7:0] ew;
    logic [7:0] ef;
    logic ec;
    logic ez;
  } bci_tb_row_t;

  localparam int LIMIT = 6000;
  localparam bci_tb_row_t ROWS [9] = '{
    '{12'h203, 8'h00, 1'b1, 1'b0, 8'h00, 8'h00, 1'b1, 1'b1},
    '{12'h224, 8'hA5, 1'b0, 1'b1, 8'h5A, 8'hA5, 1'b0, 1'b0},
    '{12'h21F, 8'h80, 1'b0, 1'b1, 8'h80, 8'h80, 1'b0, 1'b0},
    '{12'h345, 8'h81, 1'b0, 1'b1, 8'h02, 8'h81, 1'b1, 1'b1},
    '{12'h366, 8'h7F, 1'b1, 1'b0, 8'h5A, 8'hFF, 1'b0, 1'b0},
    '{12'hCFF, 8'h00, 1'b1, 1'b1, 8'hFF, 8'h00, 1'b1, 1'b1},
    '{12'hC00, 8'h33, 1'b0, 1'b0, 8'h00, 8'h33, 1'b0, 1'b0},
    '{12'h000, 8'h12, 1'b1, 1'b0, 8'h5A, 8'h12, 1'b1, 1'b0},
    '{12'h002, 8'h44, 1'b0, 1'b1, 8'h5A, 8'h44, 1'b0, 1'b1}};

  logic clk_i;
  logic rst_i;
  bci_wb_req_t req;
  bci_wb_rsp_t rsp;
  logic sleeping;
  logic [7:0] option;
  int mismatches;
  int comparisons;
  int cycles = 0;

  bci_core #(.WDT_PRESCALE(4)) i_dut (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wb_req_i(req),
    .wb_rsp_o(rsp),
    .sleeping_o(sleeping),
    .option_o(option)
  );

  initial
  begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  always @(posedge clk_i)
  begin
    cycles <= cycles + 1;
    if (cycles == LIMIT)
    begin
      mismatches++;
      $display("Error at %0t: cycle ceiling reached, got %0h expected %0h", $time, cycles, 0);
      tally_and_finish();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      mismatches++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  // one classic cycle: request held until ack is sampled, then one idle cycle
  task automatic wb_cycle(input logic we, input logic [7:0] adr, input logic [31:0] wd,
                          output logic [31:0] rd);
    int n;
    n = 0;
    req.cyc <= 1'b1;
    req.stb <= 1'b1;
    req.we <= we;
    req.sel <= 4'hF;
    req.adr <= adr;
    req.dat <= wd;
    do
    begin
      @(posedge clk_i);
      n++;
    end while (rsp.ack !== 1'b1 && n < 20);
    if (n >= 20)
      chk(32'h0, 32'h1);
    rd = rsp.dat;
    req.cyc <= 1'b0;
    req.stb <= 1'b0;
    req.we <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic wb_write(input logic [7:0] adr, input logic [31:0] wd);
    logic [31:0] dummy;
    wb_cycle(1'b1, adr, wd, dummy);
  endtask

  task automatic wb_read(input logic [7:0] adr, output logic [31:0] rd);
    wb_cycle(1'b0, adr, 32'h0000_0000, rd);
  endtask

  task automatic do_reset();
    rst_i <= 1'b1;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
  endtask

  initial
  begin
    logic [31:0] rd;
    logic [31:0] pc0;
    logic [31:0] w0;
    logic [7:0] fadr;
    rst_i = 1'b1;
    req = '0;
    mismatches = 0;
    comparisons = 0;
    do_reset();
    for (int i = 0; i < 9; i++)
    begin
      fadr = BCI_OFS_FILE | {1'b0, ROWS[i].ins[4:0], 2'b00};
      wb_write(fadr, {24'h0, ROWS[i].fv});
      wb_write(BCI_OFS_WREG, 32'h0000_005A);
      wb_write(BCI_OFS_STATUS, {29'h0, ROWS[i].z_in, 1'b0, ROWS[i].c_in});
      wb_read(BCI_OFS_PC, pc0);
      wb_write(BCI_OFS_INSTR, {20'h0, ROWS[i].ins});
      wb_read(BCI_OFS_WREG, rd);
      chk(rd, {24'h0, ROWS[i].ew});
      wb_read(fadr, rd);
      chk(rd, {24'h0, ROWS[i].ef});
      wb_read(BCI_OFS_STATUS, rd);
      chk(rd & 32'h05, {29'h0, ROWS[i].ez, 1'b0, ROWS[i].ec});
      wb_read(BCI_OFS_PC, rd);
      chk(rd, pc0 + 32'd1);
      if (ROWS[i].ins == BCI_OP_LOAD_OPTION)
        chk({24'h0, option}, 32'h0000_005A);
      $display("test row %0d done", i);
    end

    // mid-run reset restores the documented start state
    do_reset();
    chk({24'h0, option}, {24'h0, BCI_RST_OPT});
    wb_read(BCI_OFS_STATUS, rd);
    chk(rd, 32'h0000_0018);
    wb_read(BCI_OFS_WREG, rd);
    chk(rd, 32'h0);
    wb_write(8'h40, 32'h0000_00AB);
    wb_read(8'h40, rd);
    chk(rd, 32'h0);
    $display("test reset done");

    // return-literal: W from the literal, program counter from the stack top
    wb_write(BCI_OFS_STACK, 32'h0000_01A5);
    wb_write(BCI_OFS_STATUS, 32'h0000_0005);
    wb_write(BCI_OFS_INSTR, 32'h0000_08C3);
    wb_read(BCI_OFS_WREG, rd);
    chk(rd, 32'h0000_00C3);
    wb_read(BCI_OFS_PC, rd);
    chk(rd, 32'h0000_01A5);
    wb_read(BCI_OFS_STATUS, rd);
    chk(rd & 32'h05, 32'h0000_0005);
    wb_read(BCI_OFS_CORE, rd);
    chk(rd & 32'h03, 32'h0);
    $display("test return done");

    // let the watchdog overflow so the time-out bit is clear before sleeping
    repeat (1100) @(posedge clk_i);
    wb_read(BCI_OFS_STATUS, rd);
    chk(rd & 32'h10, 32'h0);
    wb_write(BCI_OFS_STATUS, 32'h0000_0080);
    wb_read(BCI_OFS_PC, pc0);
    wb_read(BCI_OFS_WREG, w0);
    wb_write(BCI_OFS_INSTR, {20'h0, BCI_OP_SLEEP});
    wb_read(BCI_OFS_STATUS, rd);
    chk(rd & 32'h98, 32'h0000_0090);
    chk({31'h0, sleeping}, 32'h1);
    wb_read(BCI_OFS_WDT, rd);
    chk({31'h0, rd > 32'd2}, 32'h0);
    wb_write(BCI_OFS_INSTR, 32'h0000_0C77);
    wb_read(BCI_OFS_WREG, rd);
    chk(rd, w0);
    wb_read(BCI_OFS_PC, rd);
    chk(rd, pc0 + 32'd1);
    wb_write(BCI_OFS_CORE, 32'h0000_0001);
    chk({31'h0, sleeping}, 32'h0);
    wb_write(BCI_OFS_INSTR, 32'h0000_0C77);
    wb_read(BCI_OFS_WREG, rd);
    chk(rd, 32'h0000_0077);
    $display("test sleep done");
    tally_and_finish();
  end
endmodule
